// ==== hw/pcs_cfg_status.sv ====
// Upper part of the PHY configuration and status register, management address 19h.
// Assumes a management front end that presents decoded reads and writes on sys_clk,
// and PHY status inputs that are synchronous to sys_clk.
`timescale 1ns/1ps
`include "pcs_map.svh"

// Overview of operation
// - With the jabber drop bit set, carrier sense falls once a descrambler time-out occurs.
// - With the jabber drop bit clear, carrier sense holds through a time-out until resync.
// - The jabber drop bit resets to the inverse of the repeater strap.
// - The negotiation status bit shows whether negotiation is enabled by straps or control.
// - The far-end fault enable bit resets to zero, is writable and gates the fault function.
// - The duplex bit reads one for full duplex and zero for half duplex.
// - The speed bit reads one for 10 Mb/s and zero for 100 Mb/s.
// - The integrity flag is latched, resets to zero and sets on an unstable link.
// - When the first LED select bit is set the integrity flag drives the first LED output.
// - Reserved bits read zero and are written as zero.
module pcs_cfg_status
   import pcs_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        repeater_strap,
   input  wire logic [4:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [15:0] reg_wdata,
   output logic      [15:0] reg_rdata,
   input  wire logic        negotiation_enabled,
   input  wire logic        full_duplex,
   input  wire logic        speed_10,
   input  wire logic        unstable_link,
   input  wire logic        first_led_select,
   input  wire logic        led_default,
   output logic             first_led_output,
   input  wire logic        carrier_raw,
   input  wire logic        descr_timeout,
   input  wire logic        descr_resync,
   output logic             carrier_sense,
   input  wire logic        far_fault_detect,
   output logic             far_fault_indication,
   output logic             jabber_carrier_drop_enable,
   output logic             far_fault_indication_enable
);
   // ----------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------
   wire hit    = (reg_addr == `PCS_ADDR_CFG_STAT);
   wire wr_hit = hit & reg_wr;
   wire rd_hit = hit & reg_rd;

   logic strap_pending;
   logic cim_flag;
   pcs_crs_state_t crs_state;
   pcs_crs_state_t next_crs_state;

   // Strap is caught on the first clock after reset release, never under the reset itself
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         strap_pending              <= 1'b1;
         jabber_carrier_drop_enable <= `PCS_RST_JAB_DROP;
         far_fault_indication_enable <= `PCS_RST_FAR_FAULT_INDICATION_ENABLE;
      end else begin
         strap_pending <= 1'b0;
         if (strap_pending) begin
            jabber_carrier_drop_enable <= ~repeater_strap;
         end else if (wr_hit) begin
            jabber_carrier_drop_enable <= reg_wdata[`PCS_BIT_JAB_DROP];
         end
         if (wr_hit) begin
            far_fault_indication_enable <= reg_wdata[`PCS_BIT_FAR_FAULT_INDICATION_ENABLE];
         end
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   // Reserved bits are left zero
   wire [15:0] next_rdata = {4'h0,
                             jabber_carrier_drop_enable,
                             negotiation_enabled,
                             1'b0,
                             far_fault_indication_enable,
                             full_duplex,
                             speed_10,
                             cim_flag,
                             5'h00};

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= `PCS_RST_RDATA;
      end else if (rd_hit) begin
         reg_rdata <= next_rdata;
      end
   end

   pcs_cim_latch u_cim (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .unstable  (unstable_link),
      .rd_strobe (rd_hit),
      .flag      (cim_flag)
   );

   assign first_led_output     = first_led_select ? cim_flag : led_default;
   assign far_fault_indication = far_fault_indication_enable & far_fault_detect;

   // ----------------------------------------------------------------
   // Carrier sense through descrambler time-out
   // ----------------------------------------------------------------
   always_comb begin
      next_crs_state = crs_state;
      case (crs_state)
         PCS_CRS_IDLE: begin
            if (carrier_raw) next_crs_state = PCS_CRS_ACTIVE;
         end
         PCS_CRS_ACTIVE: begin
            if (descr_timeout) next_crs_state = PCS_CRS_TIMEOUT;
            else if (!carrier_raw) next_crs_state = PCS_CRS_IDLE;
         end
         PCS_CRS_TIMEOUT: begin
            if (descr_resync) next_crs_state = PCS_CRS_IDLE;
         end
         default: next_crs_state = PCS_CRS_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         crs_state <= PCS_CRS_IDLE;
      end else begin
         crs_state <= next_crs_state;
      end
   end

   // Time-out state: drop carrier only when enabled, else hold until resync
   wire in_timeout = (crs_state == PCS_CRS_TIMEOUT);
   assign carrier_sense = in_timeout ? ~jabber_carrier_drop_enable
                                     : (crs_state == PCS_CRS_ACTIVE);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_crs_drop_jab: assert property (@(posedge sys_clk) disable iff (rst)
      (in_timeout && jabber_carrier_drop_enable) |-> !carrier_sense)
      else $error("carrier held in time-out while drop enabled");
   chk_crs_hold_jab: assert property (@(posedge sys_clk) disable iff (rst)
      (crs_state == PCS_CRS_ACTIVE && descr_timeout && !jabber_carrier_drop_enable
       ##1 !jabber_carrier_drop_enable) |-> carrier_sense)
      else $error("carrier dropped in time-out while hold selected");
   chk_strap_load: assert property (@(posedge sys_clk) disable iff (rst)
      strap_pending |=> (jabber_carrier_drop_enable == !$past(repeater_strap)))
      else $error("jabber bit not loaded from strap");
   chk_rd_negot: assert property (@(posedge sys_clk) disable iff (rst)
      rd_hit |=> (reg_rdata[`PCS_BIT_AN_EN] == $past(negotiation_enabled)))
      else $error("negotiation status misread");
   chk_far_fault_indication_gate: assert property (@(posedge sys_clk) disable iff (rst)
      !far_fault_indication_enable |-> !far_fault_indication)
      else $error("fault indication while disabled");
   chk_rd_duplex: assert property (@(posedge sys_clk) disable iff (rst)
      rd_hit |=> (reg_rdata[`PCS_BIT_DUPLEX] == $past(full_duplex)))
      else $error("duplex status misread");
   chk_rd_speed: assert property (@(posedge sys_clk) disable iff (rst)
      rd_hit |=> (reg_rdata[`PCS_BIT_SPEED10] == $past(speed_10)))
      else $error("speed status misread");
   chk_led_route: assert property (@(posedge sys_clk) disable iff (rst)
      first_led_select |-> (first_led_output == cim_flag))
      else $error("led not showing integrity flag");
   chk_rsvd_zero: assert property (@(posedge sys_clk) disable iff (rst)
      ##1 (reg_rdata[15:12] == 4'h0 && !reg_rdata[9]))
      else $error("reserved bits not zero");
   chk_cim_clear: assert property (@(posedge sys_clk) disable iff (rst)
      (rd_hit && !unstable_link) |=> !cim_flag)
      else $error("integrity flag not cleared by read");

   // Read snapshot and write path; a write in the strap cycle loses bit 11 to the strap
   chk_rd_jab: assert property (@(posedge sys_clk) disable iff (rst)
      rd_hit |=> (reg_rdata[`PCS_BIT_JAB_DROP] == $past(jabber_carrier_drop_enable)))
      else $error("jabber drop bit misread");
   chk_rd_far_fault_indication: assert property (@(posedge sys_clk) disable iff (rst)
      rd_hit |=> (reg_rdata[`PCS_BIT_FAR_FAULT_INDICATION_ENABLE] == $past(far_fault_indication_enable)))
      else $error("fault enable bit misread");
   chk_rd_cim: assert property (@(posedge sys_clk) disable iff (rst)
      rd_hit |=> (reg_rdata[`PCS_BIT_CIM] == $past(cim_flag)))
      else $error("integrity flag misread");
   chk_jab_write: assert property (@(posedge sys_clk) disable iff (rst)
      (wr_hit && !strap_pending) |=>
         (jabber_carrier_drop_enable == $past(reg_wdata[`PCS_BIT_JAB_DROP])))
      else $error("jabber drop bit not written");
   chk_far_fault_indication_write: assert property (@(posedge sys_clk) disable iff (rst)
      wr_hit |=> (far_fault_indication_enable == $past(reg_wdata[`PCS_BIT_FAR_FAULT_INDICATION_ENABLE])))
      else $error("fault enable bit not written");
   chk_far_fault_indication_pass: assert property (@(posedge sys_clk) disable iff (rst)
      (far_fault_indication_enable && far_fault_detect) |-> far_fault_indication)
      else $error("fault indication missing while enabled");
   chk_led_default: assert property (@(posedge sys_clk) disable iff (rst)
      !first_led_select |-> (first_led_output == led_default))
      else $error("led not showing its normal source");
   // Carrier state walk around the descrambler time-out
   chk_crs_to_entry: assert property (@(posedge sys_clk) disable iff (rst)
      (crs_state == PCS_CRS_ACTIVE && descr_timeout) |=> in_timeout)
      else $error("time-out not entered");
   chk_crs_resync: assert property (@(posedge sys_clk) disable iff (rst)
      (in_timeout && descr_resync) |=> !in_timeout)
      else $error("time-out not left on resync");
   chk_crs_idle: assert property (@(posedge sys_clk) disable iff (rst)
      (crs_state == PCS_CRS_IDLE) |-> !carrier_sense)
      else $error("carrier sense while idle");

   cov_timeout_drop: cover property (@(posedge sys_clk) disable iff (rst)
      in_timeout && jabber_carrier_drop_enable);
   cov_timeout_hold: cover property (@(posedge sys_clk) disable iff (rst)
      in_timeout ##[1:20] descr_resync);
   cov_cim_read: cover property (@(posedge sys_clk) disable iff (rst)
      cim_flag && rd_hit);
   cov_far_fault_indication_on: cover property (@(posedge sys_clk) disable iff (rst)
      far_fault_indication);
   cov_set_on_read: cover property (@(posedge sys_clk) disable iff (rst)
      rd_hit && unstable_link);
endmodule

// ==== hw/pcs_cim_latch.sv ====
// Latched-high flag for the carrier integrity monitor.
// Assumes the event input and the read strobe are synchronous to sys_clk.
`timescale 1ns/1ps
`include "pcs_map.svh"
module pcs_cim_latch
   import pcs_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic unstable,
   input  wire logic rd_strobe,
   output logic      flag
);
   // Event wins over the read clear so no unstable cycle is ever lost
   wire next_flag_set = unstable;
   wire next_flag_clr = rd_strobe & ~unstable;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         flag <= `PCS_RST_CIM;
      end else if (next_flag_set) begin
         flag <= 1'b1;
      end else if (next_flag_clr) begin
         flag <= 1'b0;
      end
   end

   chk_flag_sets: assert property (@(posedge sys_clk) disable iff (rst)
      unstable |=> flag) else $error("integrity flag did not latch");
   chk_flag_holds: assert property (@(posedge sys_clk) disable iff (rst)
      (flag && !rd_strobe) |=> flag) else $error("integrity flag dropped unread");
endmodule

// ==== inc/pcs_map.svh ====
// Register map constants for the PHY configuration and status register (upper bits).
// Assumes a 5-bit management register address and 16-bit register data.
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH
`define PCS_ADDR_CFG_STAT   5'h19
`define PCS_BIT_JAB_DROP    11
`define PCS_BIT_AN_EN       10
`define PCS_BIT_FAR_FAULT_INDICATION_ENABLE     8
`define PCS_BIT_DUPLEX      7
`define PCS_BIT_SPEED10     6
`define PCS_BIT_CIM         5
`define PCS_RST_FAR_FAULT_INDICATION_ENABLE     1'b0
`define PCS_RST_CIM         1'b0
`define PCS_RST_JAB_DROP    1'b0
`define PCS_RST_RDATA       16'h0000
`endif

// ==== inc/pcs_pkg.sv ====
// Types shared by the configuration and status register bank.
// Assumes nothing beyond the map header.
package pcs_pkg;
   typedef enum logic [1:0] {
      PCS_CRS_IDLE    = 2'b00,
      PCS_CRS_ACTIVE  = 2'b01,
      PCS_CRS_TIMEOUT = 2'b10
   } pcs_crs_state_t;
endpackage

// ==== test/pcs_mgmt_model.sv ====
// Management entity model: decoded register reads and writes.
// Assumes tasks are called by the bench and drive just after a falling edge.
`timescale 1ns/1ps
module pcs_mgmt_model (
   input  wire logic        sys_clk,
   output logic      [4:0]  reg_addr,
   output logic             reg_wr,
   output logic             reg_rd,
   output logic      [15:0] reg_wdata,
   input  wire logic [15:0] reg_rdata
);
   initial begin
      reg_addr  = 5'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_wdata = 16'h0000;
   end
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(negedge sys_clk);
      reg_addr  = ser_addr(a);
      reg_wdata = d & 16'h0dff;
      reg_wr    = 1'b1;
      @(negedge sys_clk);
      reg_wr    = 1'b0;
      // Released data shows junk, so a stale value can never pass
      reg_wdata = ~reg_wdata;
   endtask
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(negedge sys_clk);
      reg_addr = ser_addr(a);
      reg_rd   = 1'b1;
      @(negedge sys_clk);
      reg_rd   = 1'b0;
      d        = reg_rdata;
   endtask
   // Address is assembled one bit at a time, most significant first, as on the serial link
   function automatic logic [4:0] ser_addr(input logic [4:0] a);
      logic [4:0] s;
      s = 5'h00;
      for (int b = 4; b >= 0; b--) begin
         s = {s[3:0], a[b]};
      end
      return s;
   endfunction
   function automatic logic fields_valid(input logic [15:0] v, input logic done, input logic link);
      return !v[10] || done || link;
   endfunction
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the configuration and status register.
// Assumes the register port answers one edge after each request.
`timescale 1ns/1ps
`include "pcs_map.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module testbench;
   logic sys_clk, rst, repeater_strap, reg_wr, reg_rd, negotiation_enabled, full_duplex;
   logic speed_10, unstable_link, first_led_select, led_default, first_led_output;
   logic carrier_raw, descr_timeout, descr_resync, carrier_sense;
   logic far_fault_detect, far_fault_indication;
   logic jabber_carrier_drop_enable, far_fault_indication_enable;
   logic [4:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, v;
   int          n_mismatch, compares;
   pcs_cfg_status dut (.sys_clk(sys_clk), .rst(rst), .repeater_strap(repeater_strap),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .negotiation_enabled(negotiation_enabled),
      .full_duplex(full_duplex), .speed_10(speed_10), .unstable_link(unstable_link),
      .first_led_select(first_led_select), .led_default(led_default),
      .first_led_output(first_led_output), .carrier_raw(carrier_raw),
      .descr_timeout(descr_timeout), .descr_resync(descr_resync),
      .carrier_sense(carrier_sense), .far_fault_detect(far_fault_detect),
      .far_fault_indication(far_fault_indication),
      .jabber_carrier_drop_enable(jabber_carrier_drop_enable),
      .far_fault_indication_enable(far_fault_indication_enable));
   pcs_mgmt_model mgt (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Active carrier, time-out, then resync; in_to is carrier sense held in time-out
   task automatic carrier_run(input logic in_to);
      carrier_raw = 1'b1;
      repeat (2) @(negedge sys_clk);
      `CHK("carrier active", 1'b1, carrier_sense)
      descr_timeout = 1'b1;
      @(negedge sys_clk);
      descr_timeout = 1'b0;
      carrier_raw   = 1'b0;
      @(negedge sys_clk);
      `CHK("carrier in time-out", in_to, carrier_sense)
      descr_resync = 1'b1;
      @(negedge sys_clk);
      descr_resync = 1'b0;
      @(negedge sys_clk);
      `CHK("carrier after resync", 1'b0, carrier_sense)
   endtask
   initial begin
      {repeater_strap, negotiation_enabled, full_duplex, speed_10, unstable_link} = 5'h00;
      {first_led_select, led_default, carrier_raw, descr_timeout, descr_resync} = 5'h00;
      far_fault_detect = 1'b0;
      n_mismatch = 0;
      compares   = 0;
      rst = 1'b1;
      repeat (20) @(negedge sys_clk);
      rst = 1'b0;
      repeat (2) @(negedge sys_clk);
      mgt.rd(`PCS_ADDR_CFG_STAT, v);
      `CHK("reset value", 16'h0800, v)
      `CHK("jabber enable pin", 1'b1, jabber_carrier_drop_enable)
      for (int i = 0; i < 8; i++) begin
         {negotiation_enabled, full_duplex, speed_10} = i[2:0];
         mgt.rd(`PCS_ADDR_CFG_STAT, v);
         if (mgt.fields_valid(v, 1'b1, 1'b0))
            `CHK("status", {4'h0, 1'b1, i[2], 2'b00, i[1], i[0], 6'h00}, v)
      end
      {negotiation_enabled, full_duplex, speed_10} = 3'h0;
      mgt.wr(`PCS_ADDR_CFG_STAT, 16'hffff);
      mgt.rd(`PCS_ADDR_CFG_STAT, v);
      `CHK("write back", 16'h0900, v)
      `CHK("fault enable pin", 1'b1, far_fault_indication_enable)
      far_fault_detect = 1'b1;
      @(negedge sys_clk);
      `CHK("fault enabled", 1'b1, far_fault_indication)
      mgt.rd(5'h18, v);
      `CHK("unmapped read", 16'h0900, v)
      carrier_run(1'b0);
      mgt.wr(`PCS_ADDR_CFG_STAT, 16'h0000);
      @(negedge sys_clk);
      `CHK("fault disabled", 1'b0, far_fault_indication)
      `CHK("jabber enable cleared", 1'b0, jabber_carrier_drop_enable)
      carrier_run(1'b1);
      first_led_select = 1'b1;
      unstable_link    = 1'b1;
      @(negedge sys_clk);
      unstable_link = 1'b0;
      @(negedge sys_clk);
      `CHK("led shows flag", 1'b1, first_led_output)
      mgt.rd(`PCS_ADDR_CFG_STAT, v);
      `CHK("flag latched", 16'h0020, v)
      mgt.rd(`PCS_ADDR_CFG_STAT, v);
      `CHK("flag cleared", 16'h0000, v)
      first_led_select = 1'b0;
      led_default      = 1'b1;
      @(negedge sys_clk);
      `CHK("led default", 1'b1, first_led_output)
      repeater_strap = 1'b1;
      rst = 1'b1;
      repeat (20) @(negedge sys_clk);
      rst = 1'b0;
      repeat (2) @(negedge sys_clk);
      mgt.rd(`PCS_ADDR_CFG_STAT, v);
      `CHK("strap high reset", 16'h0000, v)
      `CHK("jabber enable strap high", 1'b0, jabber_carrier_drop_enable)
      conclude();
   end
endmodule
